// ==== smc_consts.svh ====
// constants of the smbus configuration slave
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define SMC_CMD_WR      8'hBE
`define SMC_CMD_REQ     8'hBA
`define SMC_CMD_RD      8'hBD
`define SMC_CMD_PCALL   8'hCD

// ----------------------------------------------------------------------
// byte counts and command byte fields
// ----------------------------------------------------------------------
`define SMC_CNT_WR      8'h08
`define SMC_CNT_REQ     8'h04
`define SMC_OP_WR       3'h3
`define SMC_OP_RD       3'h4
`define SMC_PORT_MAX    5'h02

// ----------------------------------------------------------------------
// byte positions inside a packet, address byte is 0
// ----------------------------------------------------------------------
`define SMC_IDX_ADDR    4'h0
`define SMC_IDX_CMD     4'h1
`define SMC_IDX_COUNT   4'h2
`define SMC_IDX_CB1     4'h3
`define SMC_IDX_CB2     4'h4
`define SMC_IDX_CB3     4'h5
`define SMC_IDX_CB4     4'h6
`define SMC_IDX_D1      4'h7
`define SMC_IDX_D4      4'hA
`define SMC_IDX_PEC_WR  4'hB
`define SMC_IDX_PEC_REQ 4'h7
`define SMC_IDX_LAST    4'hF

// ----------------------------------------------------------------------
// read answer byte positions
// ----------------------------------------------------------------------
`define SMC_TX_COUNT    3'h0
`define SMC_TX_D1       3'h1
`define SMC_TX_D2       3'h2
`define SMC_TX_D3       3'h3
`define SMC_TX_D4       3'h4
`define SMC_TX_PEC      3'h5
`define SMC_TX_LAST     3'h7
`define SMC_TX_FILL     8'hFF

// ----------------------------------------------------------------------
// slave address and control register
// ----------------------------------------------------------------------
`define SMC_ADDR_HI     4'hD
`define SMC_STRAP_WAIT  2'h3
`define SMC_CTL_DW      10'h0D1
`define SMC_CTL_PORT    5'h00
`define SMC_CTL_AD_MSB  7
`define SMC_CTL_AD_LSB  1
`define SMC_CTL_CHK     9

// ----------------------------------------------------------------------
// packet error code and bit counting
// ----------------------------------------------------------------------
`define SMC_CRC_POLY    8'h07
`define SMC_CRC_INIT    8'h00
`define SMC_BITS        4'h8

`endif

// ==== smc_pkg.sv ====
// types of the smbus configuration slave
package smc_pkg;

	// ------------------------------------------------------------------
	// link state machine
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		SMC_IDLE = 3'b000,
		SMC_RX   = 3'b001,
		SMC_ACK  = 3'b010,
		SMC_TX   = 3'b011,
		SMC_MACK = 3'b100,
		SMC_SKIP = 3'b101
	} smc_st_e;

	// ------------------------------------------------------------------
	// whole state of the slave
	// ------------------------------------------------------------------
	typedef struct packed {
		smc_st_e     st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [3:0]  byten;
		logic        rw;
		logic [7:0]  cmd;
		logic [4:0]  port;
		logic [3:0]  be;
		logic [9:0]  addr;
		logic [31:0] wdata;
		logic        err;
		logic        wr_ok;
		logic        active;
		logic        mack;
		logic [7:0]  crc;
		logic [2:0]  txidx;
		logic [31:0] rdata;
		logic        rd_pend;
		logic        rd_ok;
		logic [6:0]  saddr;
		logic        chk_off;
		logic [1:0]  init_cnt;
		logic        scl_q;
		logic        sda_q;
		logic        scl_out;
		logic        sda_out;
		logic        scl_oe_n;
		logic        sda_oe_n;
		logic        req;
		logic        wr;
		logic [4:0]  q_port;
		logic [9:0]  q_addr;
		logic [3:0]  q_be;
		logic [31:0] q_wdata;
	} smc_state_s;

endpackage : smc_pkg

// ==== smc_sync.sv ====
// two flip-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
`default_nettype none

module smc_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= INIT;
			dout <= INIT;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule : smc_sync

`default_nettype wire

// ==== smc_crc8.sv ====
// one byte step of the packet error code, crc-8 x^8+x^2+x+1
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.svh"

module smc_crc8 (
	input  wire logic [7:0] crc_in,
	input  wire logic [7:0] din,
	output logic      [7:0] crc_out
);

	always_comb begin
		logic [7:0] c;
		c = crc_in ^ din;
		for (int i = 0; i < 8; i++) begin
			if (c[7]) begin
				c = {c[6:0], 1'b0} ^ `SMC_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc_out = c;
	end

endmodule : smc_crc8

`default_nettype wire

// ==== smc_slave.sv ====
// smbus slave giving an smbus master access to configuration registers
// Function
// - acts purely as an smbus slave: takes write data, returns read data
// - master can read and write every read/write configuration register
// - read-only and hardware_initialized registers are also writable here
// - clock and data pins are both two-way; clock line may be driven
// - default address: straps in bits 2:0, fixed 1,0,1,1 in bits 3 to 6
// - software may override the address via control register 344h bits 7:1
// - only block write, block read and process call are supported
// - packet error code is checked on receive and generated on transmit
// - register write is a block write with command code BEh
// - register read: block write BAh request, then block read BDh
// - process call with codes BAh and CDh also reads a register
// - a wrong byte after the address byte and every later byte of the packet are nacked
// - byte after data byte 4 is the error code; failure drops write
// - byte enables in command byte 3 bits 5:2 gate register bytes
// - port select from command byte 2 bits 3:0 and byte 3 bit 7
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.svh"

module smc_slave (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic [2:0]  strap,
	input  wire logic        ctl_wr,
	input  wire logic [15:0] ctl_data,
	output logic             cfg_req,
	output logic             cfg_write,
	output logic      [4:0]  cfg_port,
	output logic      [9:0]  cfg_addr,
	output logic      [3:0]  cfg_be,
	output logic      [31:0] cfg_wdata,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_ack,
	output logic      [6:0]  slave_addr,
	output logic             error_check_off
);

	import smc_pkg::*;

	smc_state_s r;
	smc_state_s n;
	logic       s_scl;
	logic       s_sda;
	logic [2:0] s_strap;
	logic [7:0] crc_din;
	logic [7:0] crc_nx;
	logic [7:0] tx_byte;

	// ------------------------------------------------------------------
	// pin synchronisers and crc step
	// ------------------------------------------------------------------
	smc_sync #(
		.W    (5),
		.INIT (5'h18)
	) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({scl_in, sda_in, strap}),
		.dout ({s_scl, s_sda, s_strap})
	);

	smc_crc8 u_crc (
		.crc_in  (r.crc),
		.din     (crc_din),
		.crc_out (crc_nx)
	);

	// ------------------------------------------------------------------
	// read answer byte
	// ------------------------------------------------------------------
	always_comb begin
		case (r.txidx)
			`SMC_TX_COUNT: tx_byte = `SMC_CNT_REQ;
			`SMC_TX_D1:    tx_byte = r.rdata[31:24];
			`SMC_TX_D2:    tx_byte = r.rdata[23:16];
			`SMC_TX_D3:    tx_byte = r.rdata[15:8];
			`SMC_TX_D4:    tx_byte = r.rdata[7:0];
			`SMC_TX_PEC:   tx_byte = r.crc;
			default:       tx_byte = `SMC_TX_FILL;
		endcase
	end

	assign crc_din = (r.st == SMC_TX) ? tx_byte : r.sh;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic ok;
		logic is_wr;
		logic is_pec;
		rise   = s_scl & ~r.scl_q;
		fall   = ~s_scl & r.scl_q;
		start  = r.scl_q & s_scl & r.sda_q & ~s_sda;
		stop   = r.scl_q & s_scl & ~r.sda_q & s_sda;
		ok     = 1'b0;
		is_wr  = (r.cmd == `SMC_CMD_WR);
		is_pec = is_wr ? (r.byten == `SMC_IDX_PEC_WR)
		               : (r.byten == `SMC_IDX_PEC_REQ);
		n       = r;
		n.req   = 1'b0;
		n.scl_q = s_scl;
		n.sda_q = s_sda;

		// strap capture a few cycles after reset release
		if (r.init_cnt != `SMC_STRAP_WAIT) begin
			n.init_cnt = r.init_cnt + 2'h1;
			if (r.init_cnt == `SMC_STRAP_WAIT - 2'h1) begin
				n.saddr = {`SMC_ADDR_HI, s_strap};
			end
		end
		if (ctl_wr) begin
			n.saddr   = ctl_data[`SMC_CTL_AD_MSB:`SMC_CTL_AD_LSB];
			n.chk_off = ctl_data[`SMC_CTL_CHK];
		end
		if (cfg_ack && r.rd_pend) begin
			n.rdata   = cfg_rdata;
			n.rd_ok   = 1'b1;
			n.rd_pend = 1'b0;
		end

		if (start) begin
			// repeated start keeps the running crc and error state
			if (!r.active) begin
				n.crc = `SMC_CRC_INIT;
				n.err = 1'b0;
			end
			n.active   = 1'b1;
			n.st       = SMC_RX;
			n.cnt      = 4'h0;
			n.byten    = `SMC_IDX_ADDR;
			n.sda_oe_n = 1'b1;
			n.scl_oe_n = 1'b1;
		end else if (stop) begin
			n.st       = SMC_IDLE;
			n.active   = 1'b0;
			n.sda_oe_n = 1'b1;
			n.scl_oe_n = 1'b1;
			n.wr_ok    = 1'b0;
			if (is_wr && r.wr_ok && !r.err) begin
				// write goes through to any register class
				n.req = 1'b1;
				n.wr  = 1'b1;
				if (r.port == `SMC_CTL_PORT && r.addr == `SMC_CTL_DW) begin
					if (r.be[0]) begin
						n.saddr = r.wdata[`SMC_CTL_AD_MSB:`SMC_CTL_AD_LSB];
					end
					if (r.be[1]) begin
						n.chk_off = r.wdata[`SMC_CTL_CHK];
					end
				end
			end
		end else begin
			case (r.st)
				SMC_RX: begin
					if (rise) begin
						n.sh  = {r.sh[6:0], s_sda};
						n.cnt = r.cnt + 4'h1;
					end else if (fall && r.cnt == `SMC_BITS) begin
						case (r.byten)
							`SMC_IDX_ADDR: begin
								n.rw = r.sh[0];
								ok   = (r.sh[7:1] == r.saddr) &&
								       (!r.sh[0] || r.rd_pend || r.rd_ok);
							end
							`SMC_IDX_CMD: begin
								n.cmd = r.sh;
								ok    = (r.sh == `SMC_CMD_WR) ||
								        (r.sh == `SMC_CMD_REQ) ||
								        (r.sh == `SMC_CMD_RD) ||
								        (r.sh == `SMC_CMD_PCALL);
								if (r.sh == `SMC_CMD_REQ ||
								    r.sh == `SMC_CMD_PCALL) begin
									n.rd_ok = 1'b0;
								end
							end
							`SMC_IDX_COUNT: begin
								ok = is_wr ? (r.sh == `SMC_CNT_WR)
								     : ((r.cmd != `SMC_CMD_RD) &&
								        (r.sh == `SMC_CNT_REQ));
							end
							`SMC_IDX_CB1: begin
								ok = (r.sh[2:0] == (is_wr ? `SMC_OP_WR
								                          : `SMC_OP_RD));
							end
							`SMC_IDX_CB2: begin
								n.port[4:1] = r.sh[3:0];
								ok          = 1'b1;
							end
							`SMC_IDX_CB3: begin
								n.port[0]   = r.sh[7];
								n.be        = r.sh[5:2];
								n.addr[9:8] = r.sh[1:0];
								ok = ({r.port[4:1], r.sh[7]} <= `SMC_PORT_MAX);
							end
							`SMC_IDX_CB4: begin
								n.addr[7:0] = r.sh;
								ok          = 1'b1;
								if (!is_wr && !r.err) begin
									n.req     = 1'b1;
									n.wr      = 1'b0;
									n.rd_pend = 1'b1;
								end
							end
							default: begin
								if (is_pec) begin
									ok = r.chk_off || (r.sh == r.crc);
									if (!ok) begin
										n.wr_ok   = 1'b0;
										n.rd_pend = 1'b0;
										n.rd_ok   = 1'b0;
									end
								end else if (is_wr && r.byten >= `SMC_IDX_D1 &&
								             r.byten <= `SMC_IDX_D4) begin
									n.wdata = {r.wdata[23:0], r.sh};
									ok      = 1'b1;
									if (r.byten == `SMC_IDX_D4 && !r.err) begin
										n.wr_ok = 1'b1;
									end
								end
							end
						endcase
						n.mack = ok && !r.err;
						if (!ok && r.byten != `SMC_IDX_ADDR) begin
							n.err = 1'b1;
						end
						if (r.byten != `SMC_IDX_LAST) begin
							n.byten = r.byten + 4'h1;
						end
						n.crc      = crc_nx;
						n.st       = SMC_ACK;
						n.cnt      = 4'h0;
						n.sda_oe_n = ~(ok && !r.err);
					end
				end
				SMC_ACK: begin
					if (fall) begin
						n.sda_oe_n = 1'b1;
						if (!r.mack && r.byten == `SMC_IDX_CMD) begin
							n.st = SMC_SKIP;
						end else if (r.rw && r.mack) begin
							n.st    = SMC_TX;
							n.cnt   = 4'h0;
							n.txidx = `SMC_TX_COUNT;
						end else begin
							n.st = SMC_RX;
						end
					end
				end
				SMC_TX: begin
					if (r.cnt == 4'h0) begin
						if (r.rd_ok) begin
							n.sh       = {tx_byte[6:0], 1'b0};
							n.sda_oe_n = tx_byte[7];
							n.crc      = crc_nx;
							n.scl_oe_n = 1'b1;
							n.cnt      = 4'h1;
						end else begin
							n.scl_oe_n = 1'b0;
						end
					end else if (fall) begin
						if (r.cnt == `SMC_BITS) begin
							n.sda_oe_n = 1'b1;
							n.st       = SMC_MACK;
						end else begin
							n.sda_oe_n = r.sh[7];
							n.sh       = {r.sh[6:0], 1'b0};
							n.cnt      = r.cnt + 4'h1;
						end
					end
				end
				SMC_MACK: begin
					if (rise) begin
						n.mack = ~s_sda;
					end else if (fall) begin
						if (r.mack) begin
							n.st    = SMC_TX;
							n.cnt   = 4'h0;
							if (r.txidx != `SMC_TX_LAST) begin
								n.txidx = r.txidx + 3'h1;
							end
						end else begin
							n.st = SMC_SKIP;
						end
					end
				end
				default: begin
					n.sda_oe_n = 1'b1;
					n.scl_oe_n = 1'b1;
				end
			endcase
		end
		// access fields stand from one request to the next
		if (n.req) begin
			{n.q_port, n.q_addr, n.q_be, n.q_wdata} = {n.port, n.addr, n.be,
			                                         n.wdata};
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r          <= '0;
			r.st       <= SMC_IDLE;
			r.crc      <= `SMC_CRC_INIT;
			r.saddr    <= {`SMC_ADDR_HI, 3'h0};
			r.scl_q    <= 1'b1;
			r.sda_q    <= 1'b1;
			r.scl_oe_n <= 1'b1;
			r.sda_oe_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign scl_out         = r.scl_out;
	assign sda_out         = r.sda_out;
	assign scl_oe_n        = r.scl_oe_n;
	assign sda_oe_n        = r.sda_oe_n;
	assign cfg_req         = r.req;
	assign cfg_write       = r.wr;
	assign cfg_port        = r.q_port;
	assign cfg_addr        = r.q_addr;
	assign cfg_be          = r.q_be;
	assign cfg_wdata       = r.q_wdata;
	assign slave_addr      = r.saddr;
	assign error_check_off = r.chk_off;

endmodule : smc_slave

`default_nettype wire

// ==== smc_slave_asserts.sv ====
// port assertions of the smbus configuration slave
`timescale 1ns/1ps
`default_nettype none

module smc_slave_asserts (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        scl_oe_n,
	input wire logic        sda_oe_n,
	input wire logic [2:0]  strap,
	input wire logic        ctl_wr,
	input wire logic [15:0] ctl_data,
	input wire logic        cfg_req,
	input wire logic        cfg_write,
	input wire logic [4:0]  cfg_port,
	input wire logic [9:0]  cfg_addr,
	input wire logic [3:0]  cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [6:0]  slave_addr,
	input wire logic        error_check_off
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// both lines high before a write is handed on
	sequence s_stop_seen;
		$past(scl_in, 2) && $past(sda_in, 2);
	endsequence
	// stretch begins with the clock low and ends in time
	sequence s_release;
		!scl_in ##[1:400] scl_oe_n;
	endsequence

	AST_REQ_PULSE: assert property (cfg_req |=> !cfg_req)
		else $error("request longer than one cycle");
	AST_WR_AT_STOP: assert property (cfg_req && cfg_write |-> s_stop_seen)
		else $error("write handed on before the stop");
	AST_STRAP: assert property ($rose(rstn) |-> ##5 slave_addr == {4'hD, strap})
		else $error("address not taken from the straps");
	AST_PORT: assert property (cfg_req |-> cfg_port <= 5'h02)
		else $error("port select out of range");
	AST_HOLD: assert property (!cfg_req |-> $stable({cfg_write, cfg_port,
		cfg_addr, cfg_be, cfg_wdata}))
		else $error("access fields moved without a request");
	AST_CTL_ADDR: assert property (ctl_wr |=>
		slave_addr == $past(ctl_data[7:1]))
		else $error("address override not taken");
	AST_CTL_CHK: assert property (ctl_wr |=>
		error_check_off == $past(ctl_data[9]))
		else $error("check disable not taken");
	AST_SDA_EDGE: assert property ($changed(sda_oe_n) |-> !$past(scl_in))
		else $error("data line moved while the clock was high");
	AST_STRETCH: assert property ($fell(scl_oe_n) |-> s_release)
		else $error("clock stretch out of place or too long");
endmodule : smc_slave_asserts

bind smc_slave smc_slave_asserts smc_slave_asserts_i (
	.clk, .rstn, .scl_in, .sda_in, .scl_oe_n, .sda_oe_n, .strap,
	.ctl_wr, .ctl_data, .cfg_req, .cfg_write, .cfg_port, .cfg_addr,
	.cfg_be, .cfg_wdata, .slave_addr, .error_check_off
);

`default_nettype wire

// ==== smc_host.sv ====
// smbus master model on the two open drain lines
`timescale 1ns/1ps
`default_nettype none

module smc_host (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output var logic  scl_rel,
	output var logic  sda_rel
);
	initial begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
	end

	task automatic qp(int n);
		repeat (2 * n) @(negedge clk);
	endtask : qp

	task automatic rise();
		scl_rel = 1'b1;
		repeat (400) if (!scl) @(negedge clk);
		qp(2);
	endtask : rise

	task automatic bit_io(logic b, output logic r);
		qp(1);
		sda_rel = b;
		qp(1);
		rise();
		r = sda;
		scl_rel = 1'b0;
	endtask : bit_io

	task automatic start_c();
		qp(1);
		sda_rel = 1'b1;
		qp(1);
		rise();
		sda_rel = 1'b0;
		qp(2);
		scl_rel = 1'b0;
	endtask : start_c

	task automatic stop_c();
		qp(1);
		sda_rel = 1'b0;
		qp(1);
		rise();
		sda_rel = 1'b1;
		qp(2);
	endtask : stop_c

	task automatic wr_byte(logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = (r === 1'b0);
	endtask : wr_byte

	task automatic rd_byte(output logic [7:0] d, input logic nak);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nak, r);
	endtask : rd_byte
endmodule : smc_host

`default_nettype wire

// ==== tb_smc_slave.sv ====
// self-checking bench of the smbus configuration slave
`timescale 1ns/1ps
`default_nettype none

module tb_smc_slave;
	logic        clk, rstn, scl_rel, sda_rel, scl_w, sda_w;
	logic        scl_out, scl_oe_n, sda_out, sda_oe_n;
	logic [2:0]  strap;
	logic        ctl_wr, cfg_req, cfg_write, cfg_ack, error_check_off;
	logic [15:0] ctl_data;
	logic [4:0]  cfg_port;
	logic [9:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [6:0]  slave_addr, sa;
	logic [51:0] cap;
	logic [15:0] ak;
	logic [7:0]  pc;
	logic        held = 1'b0;
	int          err_total = 0, comparisons = 0, nreq = 0, dly = 0;
	int          ack_wait = 40;

	assign scl_w = scl_rel & scl_oe_n;
	assign sda_w = sda_rel & sda_oe_n;

	smc_slave smc_slave_i (.clk, .rstn, .scl_in(scl_w), .scl_out,
		.scl_oe_n, .sda_in(sda_w), .sda_out, .sda_oe_n, .strap, .ctl_wr,
		.ctl_data, .cfg_req, .cfg_write, .cfg_port, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_rdata, .cfg_ack, .slave_addr, .error_check_off);
	smc_host smc_host_i (.clk, .scl(scl_w), .sda(sda_w), .scl_rel,
		.sda_rel);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// config side: answers reads after ack_wait cycles
	always @(negedge clk) begin
		if (scl_oe_n === 1'b0)
			held = 1'b1;
		if (cfg_req === 1'b1) begin
			nreq++;
			cap = {cfg_write, cfg_port, cfg_be, cfg_addr, cfg_wdata};
			if (cfg_write === 1'b0)
				dly = ack_wait;
		end
		cfg_ack = (dly == 1);
		if (dly > 0)
			dly--;
	end

	function automatic logic [7:0] crc(logic [7:0] c, logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		return c;
	endfunction : crc

	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic send(logic [87:0] b, int n, logic pec, logic bad);
		logic a;
		ak = 16'h0000;
		smc_host_i.start_c();
		for (int i = 0; i < n; i++) begin
			pc = crc(pc, b[8 * (n - 1 - i) +: 8]);
			smc_host_i.wr_byte(b[8 * (n - 1 - i) +: 8], a);
			ak[i] = a;
		end
		if (pec) begin
			smc_host_i.wr_byte(pc ^ {7'h00, bad}, a);
			ak[n] = a;
		end
	endtask : send

	task automatic fin();
		smc_host_i.stop_c();
		repeat (8) @(negedge clk);
	endtask : fin

	task automatic rd6(string nm);
		logic [7:0]  d;
		logic [39:0] v;
		for (int i = 0; i < 5; i++) begin
			smc_host_i.rd_byte(d, 1'b0);
			pc = crc(pc, d);
			v = {v[31:0], d};
		end
		smc_host_i.rd_byte(d, 1'b1);
		fin();
		chk(nm, 40'h04A1B2C3D4, v);
		chk("answer error code", pc, d);
	endtask : rd6

	task automatic t_write();
		int n0 = nreq;
		pc = 8'h00;
		send({sa, 1'b0, 80'hBE080301295512345678}, 11, 1'b1, 1'b0);
		fin();
		chk("write acks", 12'hFFF, ak[11:0]);
		chk("drive levels", 2'b00, {scl_out, sda_out});
		chk("write count", n0 + 1, nreq);
		chk("write fields", {1'b1, 5'h02, 4'hA, 10'h155, 32'h12345678},
			cap);
		$display("write test done");
	endtask : t_write

	task automatic t_refuse();
		int n0 = nreq;
		pc = 8'h00;
		send({sa, 1'b0, 80'hBE070301295512345678}, 11, 1'b1, 1'b0);
		fin();
		chk("count nack", 12'h003, ak[11:0]);
		pc = 8'h00;
		send({sa, 1'b0, 80'hBE080301295512345678}, 11, 1'b1, 1'b1);
		fin();
		chk("error code nack", 12'h7FF, ak[11:0]);
		send({sa ^ 7'h01, 1'b0}, 1, 1'b0, 1'b0);
		fin();
		chk("foreign nack", 1'b0, ak[0]);
		chk("refused count", n0, nreq);
		$display("refusal test done");
	endtask : t_refuse

	task automatic t_read();
		pc = 8'h00;
		send({sa, 1'b0, 48'hBA0404012955}, 7, 1'b1, 1'b0);
		fin();
		chk("request acks", 8'hFF, ak[7:0]);
		chk("read fields", {1'b0, 5'h02, 4'hA, 10'h155}, cap[51:32]);
		pc = 8'h00;
		send({sa, 1'b0, 8'hBD}, 2, 1'b0, 1'b0);
		send({sa, 1'b1}, 1, 1'b0, 1'b0);
		rd6("read answer");
		$display("read test done");
	endtask : t_read

	task automatic t_pcall();
		ack_wait = 200;
		pc = 8'h00;
		send({sa, 1'b0, 48'hCD0404012955}, 7, 1'b0, 1'b0);
		chk("call acks", 8'h7F, ak[7:0]);
		send({sa, 1'b1}, 1, 1'b0, 1'b0);
		rd6("call answer");
		chk("clock held", 1'b1, held);
		$display("process call test done");
	endtask : t_pcall

	task automatic t_ctl();
		int n0;
		ctl_data = 16'h0274;
		ctl_wr = 1'b1;
		@(negedge clk);
		ctl_wr = 1'b0;
		@(negedge clk);
		chk("new address", 7'h3A, slave_addr);
		chk("check off", 1'b1, error_check_off);
		sa = 7'h3A;
		n0 = nreq;
		pc = 8'h00;
		send({sa, 1'b0, 80'hBE080301295512345678}, 11, 1'b1, 1'b1);
		fin();
		chk("unchecked acks", 12'hFFF, ak[11:0]);
		chk("unchecked write", n0 + 1, nreq);
		$display("control test done");
	endtask : t_ctl

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	initial begin
		#2000000;
		err_total++;
		report_and_stop();
	end

	initial begin
		rstn = 1'b0;
		ctl_wr = 1'b0;
		ctl_data = 16'h0000;
		strap = 3'b101;
		cfg_rdata = 32'hA1B2C3D4;
		cfg_ack = 1'b0;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		repeat (12) @(negedge clk);
		sa = 7'h6D;
		chk("strap address", sa, slave_addr);
		chk("check on", 1'b0, error_check_off);
		t_write();
		t_refuse();
		t_read();
		t_pcall();
		t_ctl();
		report_and_stop();
	end
endmodule : tb_smc_slave

`default_nettype wire
